// >>> bmc_defs.svh
`ifndef BMC_DEFS_SVH
`define BMC_DEFS_SVH
// register byte offsets
`define BMC_OFS_CTRL     8'h00
`define BMC_OFS_COUNT    8'h04
`define BMC_OFS_RATE     8'h08
`define BMC_OFS_CARRIER  8'h0c
`define BMC_OFS_PHASE    8'h10
`define BMC_OFS_ARBPTS   8'h14
`define BMC_OFS_CMD      8'h18
`define BMC_OFS_STATUS   8'h1c
`define BMC_OFS_ERROR    8'h20
// control and count field positions
`define BMC_CTRL_EN      0
`define BMC_CTRL_TSRC_LO 1
`define BMC_CTRL_TSRC_HI 2
`define BMC_CTRL_BSRC    3
`define BMC_CTRL_MOD_LO  4
`define BMC_CTRL_MOD_HI  5
`define BMC_CTRL_SHP_LO  6
`define BMC_CTRL_SHP_HI  8
`define BMC_COUNT_INF    16
// count limits and default
`define BMC_COUNT_MIN    16'h0001
`define BMC_COUNT_MAX    16'hc350
// frequencies in units of 10 mHz
`define BMC_F_MIN        32'h0000_0001
`define BMC_F_1K         32'h0001_86a0
`define BMC_F_100K       32'h0098_9680
`define BMC_F_200K       32'h0131_2d00
`define BMC_F_1M         32'h05f5_e100
`define BMC_F_2M         32'h0beb_c200
`define BMC_F_2M5        32'h0ee6_b280
`define BMC_F_3M         32'h11e1_a300
`define BMC_F_4M         32'h17d7_8400
`define BMC_F_5M         32'h1dcd_6500
// arb point bands
`define BMC_PTS_8K       16'h2000
`define BMC_PTS_12K      16'h2fff
`define BMC_PTS_DEF      16'h2000
// one clock tick is 2.5e10 units of 10 mHz at 250 MHz
`define BMC_ACC_MOD      35'h5_d21d_ba00
`define BMC_ACC_HALF     35'h2_e90e_dd00
// phase in millidegrees, and accumulator units per millidegree
`define BMC_PH_FULL      32'h0005_7e40
`define BMC_PH_SCALE     17'h1_0f44
// burst period in clocks: 100 Hz default, 50 kHz floor
`define BMC_RATE_DEF     32'h0026_25a0
`define BMC_RATE_MIN     32'h0000_1388
// settings conflict code, -221
`define BMC_ERR_CONFLICT 16'hff23
`endif

// >>> bmc_pkg.sv
package bmc_pkg;
  // trigger source choices
  typedef enum logic [1:0] {
    BMC_TSRC_INT    = 2'b00,
    BMC_TSRC_SINGLE = 2'b01,
    BMC_TSRC_EXT    = 2'b10
  } bmc_tsrc_type;
  // carrier shapes
  typedef enum logic [2:0] {
    BMC_SHP_SINE = 3'b000,
    BMC_SHP_SQR  = 3'b001,
    BMC_SHP_TRI  = 3'b010,
    BMC_SHP_RAMP = 3'b011,
    BMC_SHP_ARB  = 3'b100
  } bmc_shape_type;
  // active burst mode
  typedef enum logic [1:0] {
    BMC_MODE_INT  = 2'b00,
    BMC_MODE_EXT  = 2'b01,
    BMC_MODE_GATE = 2'b10
  } bmc_mode_type;
  // sequencer states
  typedef enum logic [1:0] {
    BMC_ST_IDLE  = 2'b00,
    BMC_ST_BURST = 2'b01,
    BMC_ST_GATE  = 2'b10
  } bmc_state_type;
  // what the block hands to the synthesizer and panel
  typedef struct packed {
    logic        carrier_on;
    logic        sync;
    logic        trig_wait;
    logic        ext_wait;
    logic        burst_ind;
    logic        other_mod_off;
    logic [15:0] phase;
  } bmc_out_type;
endpackage : bmc_pkg

// >>> bmc_burst_ctrl.sv
`timescale 1ns/100ps
`include "bmc_defs.svh"
// How it works
// R1 - each trigger emits exactly count carrier cycles
// R2 - output held at offset between bursts
// R3 - power-on selects internally triggered mode
// R4 - sources select exactly one burst mode
// R5 - trigger source internal, single, external; internal default
// R6 - internal source fires bursts at burst rate
// R7 - single source also arms external trigger
// R8 - external trigger acts on rising edge
// R9 - trigger wait flag while awaiting trigger
// R10 - single/external use count and phase, not rate
// R11 - gated burst source overrides trigger source
// R12 - burst source internal or gate; internal default
// R13 - gated: carrier while gate high, else offset
// R14 - gated ignores count, rate, phase, source
// R15 - external wait flag while gate awaited
// R16 - burst flag lit; burst disables other modulation
// R17 - host programs parameters before enabling burst
// R18 - cycles produced at carrier frequency
// R19 - carrier limited 10 mHz..5 MHz, 100 kHz tri/ramp
// R20 - arb carrier limit depends on point count
// R21 - low counts cap carrier in MHz bands
// R22 - invalid carrier clamped, conflict error logged
// R23 - count 1..50000 or infinite, default one
// R24 - triggered sync low during burst, else high
// R25 - gated sync high above offset, low below
// R26 - triggers during a burst are dropped
module bmc_burst_ctrl (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               ext_trig,
  output bmc_pkg::bmc_out_type    bout
);
  // software-visible settings
  logic                   burst_en;     // burst modulation on
  bmc_pkg::bmc_tsrc_type  tsrc;         // trigger source
  logic                   bsrc_gate;    // burst source is external gate
  logic [1:0]             other_mod;    // other modulation selection
  bmc_pkg::bmc_shape_type shape;        // carrier shape
  logic [15:0]            count;        // cycles per burst
  logic                   count_inf;    // infinite burst
  logic [31:0]            rate;         // clocks between internal bursts
  logic [31:0]            carrier;      // carrier in 10 mHz units
  logic [31:0]            phase_md;     // start phase in millidegrees
  logic [15:0]            arb_pts;      // arb waveform length
  logic                   err_flag;     // settings conflict logged
  // sequencer
  bmc_pkg::bmc_state_type state;
  logic [34:0]            rel_acc;      // phase since burst start
  logic [15:0]            cycles;       // completed cycles in burst
  logic [31:0]            rate_cnt;     // internal rate generator
  logic                   trig_s1;      // pin synchroniser
  logic                   trig_s2;
  logic                   trig_d;       // for edge detect

  // apb decode
  wire acc_phase  = psel & penable & pready;
  wire wr_en      = acc_phase & pwrite;
  wire setup      = psel & ~penable;
  wire wr_ctrl    = wr_en & (paddr == `BMC_OFS_CTRL);
  wire wr_count   = wr_en & (paddr == `BMC_OFS_COUNT);
  wire wr_rate    = wr_en & (paddr == `BMC_OFS_RATE);
  wire wr_carrier = wr_en & (paddr == `BMC_OFS_CARRIER);
  wire wr_phase   = wr_en & (paddr == `BMC_OFS_PHASE);
  wire wr_pts     = wr_en & (paddr == `BMC_OFS_ARBPTS);
  wire wr_cmd     = wr_en & (paddr == `BMC_OFS_CMD);
  wire wr_err     = wr_en & (paddr == `BMC_OFS_ERROR);
  wire mapped     = (paddr <= `BMC_OFS_ERROR) & (paddr[1:0] == 2'b00);

  // mode choice from the two sources
  wire bmc_pkg::bmc_mode_type mode =
    bsrc_gate ? bmc_pkg::BMC_MODE_GATE :                          // R4 R11
    (tsrc == bmc_pkg::BMC_TSRC_INT) ? bmc_pkg::BMC_MODE_INT :
                                      bmc_pkg::BMC_MODE_EXT;      // R4

  // carrier limit for the present shape, points and count
  wire tri_ramp = (shape == bmc_pkg::BMC_SHP_TRI) | (shape == bmc_pkg::BMC_SHP_RAMP);
  wire [31:0] arb_max =
    (arb_pts <= `BMC_PTS_8K)  ? `BMC_F_5M :
    (arb_pts <= `BMC_PTS_12K) ? `BMC_F_2M5 : `BMC_F_200K;         // R20
  wire [31:0] shape_max =
    tri_ramp ? `BMC_F_100K :
    (shape == bmc_pkg::BMC_SHP_ARB) ? arb_max : `BMC_F_5M;        // R19
  wire [31:0] count_max =
    (count_inf | (count >= 16'h0005)) ? `BMC_F_5M :
    (count == 16'h0004) ? `BMC_F_4M :
    (count == 16'h0003) ? `BMC_F_3M :
    (count == 16'h0002) ? `BMC_F_2M : `BMC_F_1M;                 // R21
  wire [31:0] f_max = (!tri_ramp && count_max < shape_max) ? count_max : shape_max;
  wire        f_high = pwdata > f_max;
  wire        f_low  = pwdata < `BMC_F_MIN;
  wire [31:0] f_clamp = f_high ? f_max : (f_low ? `BMC_F_MIN : pwdata);  // R22

  // count write kept within 1..50000
  wire [15:0] cnt_req = pwdata[15:0];
  wire [15:0] cnt_clamp =
    (pwdata[31:16] != 16'h0000 || cnt_req > `BMC_COUNT_MAX) ? `BMC_COUNT_MAX :
    (cnt_req < `BMC_COUNT_MIN) ? `BMC_COUNT_MIN : cnt_req;       // R23

  // phase write kept within plus/minus one turn
  wire signed [31:0] ph_req = $signed(pwdata);
  wire signed [31:0] ph_full = $signed(`BMC_PH_FULL);
  wire [31:0] ph_clamp =
    (ph_req > ph_full) ? `BMC_PH_FULL :
    (ph_req < -ph_full) ? (32'h0 - `BMC_PH_FULL) : pwdata;

  // start offset in accumulator units; slight rounding of the scale
  // keeps the divide out of the datapath
  wire [31:0] ph_pos = phase_md[31] ? (phase_md + `BMC_PH_FULL) : phase_md;
  wire [18:0] ph_norm = (ph_pos == `BMC_PH_FULL) ? 19'h0 : ph_pos[18:0];
  wire [35:0] start_prod = ph_norm * `BMC_PH_SCALE;
  wire [34:0] start_acc = start_prod[34:0];

  // triggers: rising edge of synchronised pin, single key, rate counter
  wire ext_edge  = trig_s2 & ~trig_d;                             // R8
  wire single_kp = wr_cmd & pwdata[0];
  wire rate_hit  = (rate_cnt == 32'h0);
  wire trig_now  =
    (mode == bmc_pkg::BMC_MODE_INT) ? rate_hit :                  // R6
    (ext_edge | single_kp);                                       // R7 R10
  wire start_burst = burst_en & (state == bmc_pkg::BMC_ST_IDLE) &
                     (mode != bmc_pkg::BMC_MODE_GATE) & trig_now; // R26

  // carrier accumulator step and wrap at the cycle boundary
  wire [34:0] acc_sum = rel_acc + {3'b000, carrier};              // R18
  wire        wrap    = acc_sum >= `BMC_ACC_MOD;
  wire [34:0] next_rel = wrap ? (acc_sum - `BMC_ACC_MOD) : acc_sum;
  wire        last_cyc = wrap & ~count_inf & (cycles + 16'h0001 >= count);  // R1

  // absolute phase for the synthesizer
  wire [35:0] abs_sum = {1'b0, rel_acc} + {1'b0, start_acc};
  wire [34:0] abs_acc =
    (state == bmc_pkg::BMC_ST_GATE) ? rel_acc :                   // R14
    ((abs_sum >= {1'b0, `BMC_ACC_MOD}) ? abs_sum[34:0] - `BMC_ACC_MOD : abs_sum[34:0]);

  // sequencer next state
  bmc_pkg::bmc_state_type next_state;
  always_comb begin
    next_state = state;
    case (state)
      bmc_pkg::BMC_ST_IDLE: begin
        if (burst_en && mode == bmc_pkg::BMC_MODE_GATE)
          next_state = bmc_pkg::BMC_ST_GATE;                      // R13
        else if (start_burst)
          next_state = bmc_pkg::BMC_ST_BURST;                     // R1
      end
      bmc_pkg::BMC_ST_BURST: begin
        if (!burst_en || mode == bmc_pkg::BMC_MODE_GATE || last_cyc)
          next_state = bmc_pkg::BMC_ST_IDLE;                      // R1
      end
      bmc_pkg::BMC_ST_GATE: begin
        if (!burst_en || mode != bmc_pkg::BMC_MODE_GATE)
          next_state = bmc_pkg::BMC_ST_IDLE;
      end
      default: next_state = bmc_pkg::BMC_ST_IDLE;
    endcase
  end

  // read mux
  wire [31:0] ctrl_rd = {23'h0, shape, other_mod, bsrc_gate, tsrc, burst_en};
  wire [31:0] stat_rd = {26'h0, bout.ext_wait, bout.trig_wait, state, mode};
  wire [31:0] next_rdata =
    (paddr == `BMC_OFS_CTRL)    ? ctrl_rd :
    (paddr == `BMC_OFS_COUNT)   ? {15'h0, count_inf, count} :
    (paddr == `BMC_OFS_RATE)    ? rate :
    (paddr == `BMC_OFS_CARRIER) ? carrier :
    (paddr == `BMC_OFS_PHASE)   ? phase_md :
    (paddr == `BMC_OFS_ARBPTS)  ? {16'h0, arb_pts} :
    (paddr == `BMC_OFS_STATUS)  ? stat_rd :
    (paddr == `BMC_OFS_ERROR)   ? {15'h0, err_flag, (err_flag ? `BMC_ERR_CONFLICT : 16'h0)} :
                                  32'h0;

  // apb answer: one wait-free access phase after each setup
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= setup ? next_rdata : prdata;
    end
  end

  // control register; burst and other modulation exclude each other
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      burst_en  <= 1'b0;
      tsrc      <= bmc_pkg::BMC_TSRC_INT;                          // R3 R5
      bsrc_gate <= 1'b0;                                          // R3 R12
      other_mod <= 2'b00;
      shape     <= bmc_pkg::BMC_SHP_SINE;
    end else if (wr_ctrl) begin
      burst_en  <= pwdata[`BMC_CTRL_EN];
      tsrc      <= (pwdata[`BMC_CTRL_TSRC_HI:`BMC_CTRL_TSRC_LO] == 2'b11) ?
                   bmc_pkg::BMC_TSRC_INT :
                   bmc_pkg::bmc_tsrc_type'(pwdata[`BMC_CTRL_TSRC_HI:`BMC_CTRL_TSRC_LO]);
      bsrc_gate <= pwdata[`BMC_CTRL_BSRC];                        // R12
      other_mod <= pwdata[`BMC_CTRL_EN] ? 2'b00 :
                   pwdata[`BMC_CTRL_MOD_HI:`BMC_CTRL_MOD_LO];     // R16
      shape     <= (pwdata[`BMC_CTRL_SHP_HI:`BMC_CTRL_SHP_LO] > 3'b100) ?
                   bmc_pkg::BMC_SHP_SINE :
                   bmc_pkg::bmc_shape_type'(pwdata[`BMC_CTRL_SHP_HI:`BMC_CTRL_SHP_LO]);
    end
  end

  // parameter registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count     <= `BMC_COUNT_MIN;                                // R23
      count_inf <= 1'b0;
      rate      <= `BMC_RATE_DEF;
      carrier   <= `BMC_F_1K;                                     // R19
      phase_md  <= 32'h0;
      arb_pts   <= `BMC_PTS_DEF;
    end else begin
      if (wr_count) begin
        count     <= cnt_clamp;                                   // R23
        count_inf <= pwdata[`BMC_COUNT_INF];
      end
      if (wr_rate)
        rate <= (pwdata < `BMC_RATE_MIN) ? `BMC_RATE_MIN : pwdata;
      if (wr_carrier)
        carrier <= f_clamp;                                       // R22
      if (wr_phase)
        phase_md <= ph_clamp;
      if (wr_pts)
        arb_pts <= pwdata[15:0];
    end
  end

  // conflict flag: set by a clamped carrier write, write one to clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      err_flag <= 1'b0;
    else if (wr_carrier && (f_high || f_low))
      err_flag <= 1'b1;                                           // R22
    else if (wr_err && pwdata[0])
      err_flag <= 1'b0;
  end

  // external trigger pin: two flops, then an edge detector on the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_d  <= 1'b0;
    end else begin
      trig_s1 <= ext_trig;
      trig_s2 <= trig_s1;
      trig_d  <= trig_s2;
    end
  end

  // internal rate generator; restarts on every hit so the interval is steady
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      rate_cnt <= `BMC_RATE_DEF;
    else if (!burst_en || mode != bmc_pkg::BMC_MODE_INT || rate_hit)
      rate_cnt <= rate - 32'h1;                                   // R6
    else
      rate_cnt <= rate_cnt - 32'h1;
  end

  // sequencer and accumulator; gated phase only advances with the gate high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state   <= bmc_pkg::BMC_ST_IDLE;
      rel_acc <= 35'h0;
      cycles  <= 16'h0;
    end else begin
      state <= next_state;
      if (start_burst) begin
        rel_acc <= 35'h0;
        cycles  <= 16'h0;
      end else if (state == bmc_pkg::BMC_ST_BURST ||
                   (state == bmc_pkg::BMC_ST_GATE && trig_s2)) begin
        rel_acc <= next_rel;                                      // R18
        cycles  <= wrap ? cycles + 16'h0001 : cycles;
      end
    end
  end

  // registered outputs
  wire gate_on = (state == bmc_pkg::BMC_ST_GATE) & trig_s2;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      bout <= '{carrier_on: 1'b0, sync: 1'b1, trig_wait: 1'b0, ext_wait: 1'b0,
                burst_ind: 1'b0, other_mod_off: 1'b1, phase: 16'h0};
    else begin
      bout.carrier_on    <= (state == bmc_pkg::BMC_ST_BURST) | gate_on;  // R2 R13
      bout.sync          <= (state == bmc_pkg::BMC_ST_GATE) ?
                            (gate_on & (abs_acc < `BMC_ACC_HALF)) :      // R25
                            (state != bmc_pkg::BMC_ST_BURST);            // R24
      bout.trig_wait     <= burst_en & (mode == bmc_pkg::BMC_MODE_EXT) &
                            (state == bmc_pkg::BMC_ST_IDLE);             // R9
      bout.ext_wait      <= burst_en & (mode == bmc_pkg::BMC_MODE_GATE) &
                            ~trig_s2;                                    // R15
      bout.burst_ind     <= burst_en;                                    // R16
      bout.other_mod_off <= burst_en | (other_mod == 2'b00);             // R16
      bout.phase         <= abs_acc[34:19];
    end
  end

  // checks
  a_idle_output_off: assert property (@(posedge clk) disable iff (!rst_b)
    $past(state) == bmc_pkg::BMC_ST_IDLE |-> !bout.carrier_on)
    else $error("carrier on while idle"); // R2
  a_burst_ends_count: assert property (@(posedge clk) disable iff (!rst_b)
    state == bmc_pkg::BMC_ST_BURST && last_cyc |=> state == bmc_pkg::BMC_ST_IDLE)
    else $error("burst did not end after count"); // R1
  a_no_retrigger: assert property (@(posedge clk) disable iff (!rst_b)
    state == bmc_pkg::BMC_ST_BURST && burst_en && !last_cyc && !bsrc_gate
    |=> state == bmc_pkg::BMC_ST_BURST && $stable(count))
    else $error("burst cut short"); // R26
  a_gate_overrides: assert property (@(posedge clk) disable iff (!rst_b)
    burst_en && bsrc_gate |-> ##[1:2] state == bmc_pkg::BMC_ST_GATE)
    else $error("gate mode not entered"); // R11
  a_edge_starts: assert property (@(posedge clk) disable iff (!rst_b)
    burst_en && mode == bmc_pkg::BMC_MODE_EXT && state == bmc_pkg::BMC_ST_IDLE &&
    trig_s2 && !trig_d |=> state == bmc_pkg::BMC_ST_BURST)
    else $error("rising edge missed"); // R8
  a_sync_low_burst: assert property (@(posedge clk) disable iff (!rst_b)
    state == bmc_pkg::BMC_ST_BURST |=> !bout.sync)
    else $error("sync high during burst"); // R24
  a_carrier_limit: assert property (@(posedge clk) disable iff (!rst_b)
    wr_carrier |=> carrier <= $past(f_max) && carrier >= `BMC_F_MIN)
    else $error("carrier beyond limit"); // R19
  a_conflict_log: assert property (@(posedge clk) disable iff (!rst_b)
    wr_carrier && f_high |=> err_flag ##1 err_flag)
    else $error("conflict not logged"); // R22
  a_count_range: assert property (@(posedge clk) disable iff (!rst_b)
    count >= `BMC_COUNT_MIN && count <= `BMC_COUNT_MAX)
    else $error("count out of range"); // R23
  a_trig_wait_flag: assert property (@(posedge clk) disable iff (!rst_b)
    burst_en && mode == bmc_pkg::BMC_MODE_EXT && state == bmc_pkg::BMC_ST_IDLE
    |=> bout.trig_wait)
    else $error("trigger wait flag missing"); // R9
endmodule : bmc_burst_ctrl

// >>> bmc_trig_src.sv
`timescale 1ns/100ps
// far-side model of the trigger and gate source; it moves the pin only after a rising edge
module bmc_trig_src (
  input  wire logic clk,
  output logic      ext_trig
);
  // idle low, so the first pulse shows a clean rising edge
  initial ext_trig = 1'b0;
  // one trigger pulse of w clocks; only its leading edge should count
  task automatic pulse(input int w);
    @(posedge clk) ext_trig <= 1'b1;
    repeat (w) @(posedge clk);
    ext_trig <= 1'b0;
  endtask : pulse
  // gate level, held until the next call
  task automatic level(input logic v);
    @(posedge clk) ext_trig <= v;
  endtask : level
endmodule : bmc_trig_src

// >>> bmc_burst_ctrl_tb.sv
`timescale 1ns/100ps
`include "bmc_defs.svh"
module bmc_burst_ctrl_tb;
  typedef struct {logic [31:0] d; logic e; logic rd;} bmc_note_type; // one expected answer
  logic                 clk;
  logic                 rst_b;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [7:0]           paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 ext_trig;
  bmc_pkg::bmc_out_type bout;
  bmc_pkg::bmc_out_type rst_out;      // expected outputs in reset
  bmc_note_type         notes[$];     // expectations noted by the driver
  bmc_note_type         cur;          // note being compared
  int                   miscompares;
  int                   n_checks;
  logic [31:0]          tc[4][5];     // ctrl, points, count, request, expected carrier

  bmc_burst_ctrl u_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_trig(ext_trig), .bout(bout));
  bmc_trig_src u_src (.clk(clk), .ext_trig(ext_trig));

  always #2 clk = ~clk;

  // single compare point; case inequality so unknowns never match
  task automatic chk(input logic [31:0] s, input logic [31:0] x, input string m);
    n_checks++;
    if (s !== x) begin
      miscompares++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, m, s, x);
    end
  endtask : chk

  // apb transfer; held until pready is sampled high, released only after that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] x = 32'h0, input logic e = 1'b0);
    int n;
    notes.push_back('{x, e, !w});
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // the loop has no cycle limit and only the watchdog ends a hung wait; a single access clock with no wait state is checked after it
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    chk(n, 1, "wait states");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // waits at most lim clocks for carrier_on to become v; n gives the clocks spent
  task automatic wait_co(input logic v, input int lim, output int n);
    n = 0;
    while (bout.carrier_on !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, bout.carrier_on}, {31'h0, v}, "carrier wait");
  endtask : wait_co

  // output must stay held off for c clocks
  task automatic quiet(input int c);
    int hits;
    hits = 0;
    repeat (c) begin
      @(posedge clk);
      if (bout.carrier_on !== 1'b0) hits++;
    end
    chk(hits, 0, "output not held");
  endtask : quiet

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  // watcher: each answer takes the oldest note; read data only matters for reads
  always @(posedge clk) begin
    if (pready === 1'b1 && notes.size() > 0) begin
      cur = notes.pop_front();
      chk({31'h0, pslverr}, {31'h0, cur.e}, "slverr");
      if (cur.rd) chk(prdata, cur.d, "rdata");
    end
  end

  // watchdog, far beyond the roughly 18k clocks the tests need
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    end_of_test();
  end

  initial begin
    int n, d;
    {clk, rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(62007));
    tc = '{'{32'h80, `BMC_PTS_DEF, 1, `BMC_F_5M, `BMC_F_100K},
           '{32'h100, 32'h3000, 1, `BMC_F_5M, `BMC_F_200K},
           '{32'h0, `BMC_PTS_DEF, 2, `BMC_F_5M, `BMC_F_2M},
           '{32'h0, `BMC_PTS_DEF, 3, `BMC_F_3M, `BMC_F_3M}};
    rst_out = '0;
    rst_out.sync = 1'b1;
    rst_out.other_mod_off = 1'b1;
    repeat (20) @(posedge clk);
    chk({10'h0, bout}, {10'h0, rst_out}, "reset outputs");
    rst_b <= 1'b1;
    apb(0, `BMC_OFS_CTRL, 0, 32'h0);
    apb(0, `BMC_OFS_COUNT, 0, 32'h1);
    apb(1, `BMC_OFS_COUNT, 32'h1_ffff);
    apb(0, `BMC_OFS_COUNT, 0, {16'h0001, `BMC_COUNT_MAX});
    apb(0, 8'h24, 0, 32'h0, 1'b1);
    apb(1, 8'h24, 32'h1, 32'h0, 1'b1);
    // a clamp is exactly the case where the read-back differs from the request
    for (int i = 0; i < 4; i++) begin
      apb(1, `BMC_OFS_CTRL, tc[i][0]);
      apb(1, `BMC_OFS_ARBPTS, tc[i][1]);
      apb(1, `BMC_OFS_COUNT, tc[i][2]);
      apb(1, `BMC_OFS_CARRIER, tc[i][3]);
      apb(0, `BMC_OFS_CARRIER, 0, tc[i][4]);
      apb(0, `BMC_OFS_ERROR, 0, tc[i][3] == tc[i][4] ? 32'h0 : 32'h0001_ff23);
      apb(1, `BMC_OFS_ERROR, 32'h1);
    end
    // source pairs and the mode they select, burst still off
    apb(1, `BMC_OFS_CTRL, 32'h4);
    apb(0, `BMC_OFS_STATUS, 0, 32'h1);
    apb(1, `BMC_OFS_CTRL, 32'hc);
    apb(0, `BMC_OFS_STATUS, 0, 32'h2);
    // external triggers; parameters are set, enable comes last with a stale modulation
    apb(1, `BMC_OFS_CTRL, 32'h35);
    apb(0, `BMC_OFS_CTRL, 0, 32'h5);
    quiet(20);
    chk({bout.burst_ind, bout.other_mod_off, bout.trig_wait, bout.sync}, 4'hf, "idle");
    // width kept within the trigger latency, so the join falls on a fixed edge
    fork
      u_src.pulse($urandom_range(5, 1));
      wait_co(1, 40, n);
    join
    chk({bout.sync, bout.trig_wait}, 2'b00, "burst flags");
    fork
      u_src.pulse($urandom_range(8, 1));
      wait_co(0, 400, n);
    join
    chk(n >= 248 && n <= 252, 1, "burst length");
    quiet(300);
    chk({bout.sync, bout.trig_wait}, 2'b11, "after burst");
    // single key, then the external pin, both launch a burst
    apb(1, `BMC_OFS_PHASE, 32'h0005_7e41);
    apb(0, `BMC_OFS_PHASE, 0, `BMC_PH_FULL);
    apb(1, `BMC_OFS_PHASE, 32'h0002_bf20);
    apb(1, `BMC_OFS_CTRL, 32'h3);
    apb(1, `BMC_OFS_CMD, 32'h1);
    wait_co(1, 20, n);
    // a half-turn start phase shows in the first phase word of the burst
    chk({16'h0, bout.phase}, 32'(`BMC_ACC_HALF >> 19), "start phase");
    wait_co(0, 400, n);
    fork
      u_src.pulse($urandom_range(8, 1));
      wait_co(1, 40, n);
    join
    wait_co(0, 400, n);
    // internal rate: rise to rise spacing equals the programmed period
    apb(1, `BMC_OFS_RATE, `BMC_RATE_MIN);
    apb(1, `BMC_OFS_CTRL, 32'h1);
    wait_co(1, 6000, n);
    wait_co(0, 400, d);
    wait_co(1, 6000, n);
    chk(n + d >= 4998 && n + d <= 5002, 1, "burst period");
    // let the running burst finish, or it would still be on during the quiet span
    wait_co(0, 400, d);
    apb(1, `BMC_OFS_CTRL, 32'h5);
    quiet(6000);
    // gated: the single key is ignored, the pin level rules
    apb(1, `BMC_OFS_CTRL, 32'hb);
    apb(1, `BMC_OFS_CMD, 32'h1);
    quiet(50);
    chk({bout.ext_wait, bout.trig_wait}, 2'b10, "gate wait");
    u_src.level(1'b1);
    wait_co(1, 10, n);
    d = 0;
    repeat (200) begin
      @(posedge clk);
      if (bout.sync === 1'b1) d++;
    end
    chk(d > 60 && d < 140, 1, "gated sync");
    chk({31'h0, bout.ext_wait}, 32'h0, "gate open");
    u_src.level(1'b0);
    wait_co(0, 10, n);
    apb(1, `BMC_OFS_CTRL, 32'h0);
    quiet(5);
    chk({31'h0, bout.burst_ind}, 32'h0, "burst off");
    end_of_test();
  end
endmodule : bmc_burst_ctrl_tb
